// File: src/ipei_defines.vh
// register offsets, field positions and reset values of the input port block
`ifndef IPEI_DEFINES_VH
`define IPEI_DEFINES_VH
`define IPEI_OFF_SINGLE_FLAG    8'hc2
`define IPEI_OFF_GROUP_FLAG     8'hc3
`define IPEI_OFF_IRQ_MASK       8'hc9
`define IPEI_OFF_GROUP_SELECT   8'hca
`define IPEI_OFF_GROUP_LEVELS   8'hd0
`define IPEI_OFF_SINGLE_LEVEL   8'hd1
`define IPEI_OFF_GROUP_COMPARE  8'hd2
`define IPEI_OFF_SINGLE_COMPARE 8'hd3
`define IPEI_OFF_SLEEP_CTRL     8'hf0
`define IPEI_MASK_GROUP_BIT     0
`define IPEI_MASK_SINGLE_BIT    1
`define IPEI_RST_MASK           2'h0
`define IPEI_RST_SELECT         4'h0
`define IPEI_RST_GROUP_COMPARE  4'h0
`define IPEI_RST_SINGLE_COMPARE 1'h0
`define IPEI_RESP_OKAY          2'h0
`define IPEI_RESP_SLVERR        2'h2
`endif

// File: src/ipei_sync.v
// two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module ipei_sync #(
  parameter WIDTH = 5
) (
  // clock
  input  wire             clk,
  // pins and synchronised copy
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  // no reset: pins carry no defined value to reset to
  always @(posedge clk) begin
    meta_q <= din;
    sync_q <= meta_q;
  end
  assign dout = sync_q;
endmodule

// File: src/ipei_top.v
// five-bit input port with edge interrupts and AXI4-Lite register access
// Contract
// - single pin raises on equal to unequal
// - group raises when enabled pins stop matching
// - group condition sets group flag
// - single condition sets single flag
// - flags set regardless of mask
// - mask bits at c9, one enables
// - mask bits cleared at reset
// - single pin interrupt cancels sleep
// - pin levels readable, writes ignored
// - compare bit one falling, zero rising
// - group compares only selected pins
// - select bits at ca, reset zero
// - group flag c3, single flag c2
// - flag read clears, writes ignored
// - flags cleared at reset
// - unused upper bits read zero
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "ipei_defines.vh"
module ipei_top #(
  parameter GROUP_W = 4
) (
  // clock and reset
  input  wire               CLK,
  input  wire               SRST,
  // pins
  input  wire [GROUP_W-1:0] GROUP_PIN,
  input  wire               SINGLE_PIN,
  // cpu side
  output wire               IRQ,
  output wire               SLEEP,
  // axi4-lite write address
  input  wire [9:0]         S_AXI_AWADDR,
  input  wire               S_AXI_AWVALID,
  output wire               S_AXI_AWREADY,
  // axi4-lite write data
  input  wire [31:0]        S_AXI_WDATA,
  input  wire [3:0]         S_AXI_WSTRB,
  input  wire               S_AXI_WVALID,
  output wire               S_AXI_WREADY,
  // axi4-lite write response
  output wire [1:0]         S_AXI_BRESP,
  output wire               S_AXI_BVALID,
  input  wire               S_AXI_BREADY,
  // axi4-lite read address
  input  wire [9:0]         S_AXI_ARADDR,
  input  wire               S_AXI_ARVALID,
  output wire               S_AXI_ARREADY,
  // axi4-lite read data
  output wire [31:0]        S_AXI_RDATA,
  output wire [1:0]         S_AXI_RRESP,
  output wire               S_AXI_RVALID,
  input  wire               S_AXI_RREADY
);
  // synchronised pins
  wire [GROUP_W:0]   pins_s;
  wire [GROUP_W-1:0] group_s;
  wire               single_s;

  ipei_sync #(
    .WIDTH (GROUP_W+1)
  ) u_sync (
    .clk  (CLK),
    .din  ({SINGLE_PIN, GROUP_PIN}),
    .dout (pins_s)
  );
  assign group_s  = pins_s[GROUP_W-1:0];
  assign single_s = pins_s[GROUP_W];

  // software registers
  reg  [1:0]         mask_q;
  reg  [GROUP_W-1:0] select_q;
  reg  [GROUP_W-1:0] gcmp_q;
  reg                scmp_q;
  reg                group_flag_q;
  reg                single_flag_q;
  reg                sleep_q;
  reg                gmis_q;
  reg                smis_q;
  reg                match_valid_q;

  // comparison: pin differs from its compare bit
  wire [GROUP_W-1:0] gdiff;
  wire               gmis;
  wire               smis;
  wire               group_evt;
  wire               single_evt;

  // compare bit one: pin resting high, falling leaves the match; zero the reverse
  // unselected pins are forced to match so they never vote
  genvar gi;
  generate
    for (gi = 0; gi < GROUP_W; gi = gi + 1) begin : g_pin_cmp
      assign gdiff[gi] = (group_s[gi] ^ gcmp_q[gi]) & select_q[gi];
    end
  endgenerate
  assign gmis  = |gdiff;
  assign smis  = single_s ^ scmp_q;

  // only the transition out of full match counts, not unequal to unequal
  assign group_evt  = match_valid_q & ~gmis_q & gmis;
  assign single_evt = match_valid_q & ~smis_q & smis;

  // first cycle after reset has no valid history to compare against
  always @(posedge CLK) begin
    if (SRST) begin
      gmis_q        <= 1'b0;
      smis_q        <= 1'b0;
      match_valid_q <= 1'b0;
    end else begin
      gmis_q        <= gmis;
      smis_q        <= smis;
      match_valid_q <= 1'b1;
    end
  end

  // axi write channel
  // address and data come in either order; each is held until both are in
  reg         aw_held_q;
  reg         w_held_q;
  reg  [9:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  wire        do_write;
  wire        wr_hit;

  assign S_AXI_AWREADY = ~aw_held_q & ~bvalid_q;
  assign S_AXI_WREADY  = ~w_held_q & ~bvalid_q;
  assign do_write      = aw_held_q & w_held_q & ~bvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;

  always @(posedge CLK) begin
    if (SRST) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 10'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `IPEI_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `IPEI_RESP_OKAY : `IPEI_RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // every mapped register answers okay, even read-only ones
  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `IPEI_OFF_SINGLE_FLAG,
        `IPEI_OFF_GROUP_FLAG,
        `IPEI_OFF_IRQ_MASK,
        `IPEI_OFF_GROUP_SELECT,
        `IPEI_OFF_GROUP_LEVELS,
        `IPEI_OFF_SINGLE_LEVEL,
        `IPEI_OFF_GROUP_COMPARE,
        `IPEI_OFF_SINGLE_COMPARE,
        `IPEI_OFF_SLEEP_CTRL:    is_mapped = 1'b1;
        default:                 is_mapped = 1'b0;
      endcase
    end
  endfunction

  // one register per word: byte address is four times the register index
  wire [7:0] wr_idx;
  wire       wr_aligned;
  wire [7:0] rd_idx;
  wire       rd_aligned;

  assign wr_idx     = awaddr_q[9:2];
  assign wr_aligned = (awaddr_q[1:0] == 2'b00);
  assign rd_idx     = S_AXI_ARADDR[9:2];
  assign rd_aligned = (S_AXI_ARADDR[1:0] == 2'b00);

  assign wr_hit = is_mapped(wr_idx) && wr_aligned;

  // refused writes (unmapped or misaligned) change nothing
  wire wr_lane0;
  wire we_mask;
  wire we_select;
  wire we_gcmp;
  wire we_scmp;
  assign wr_lane0  = do_write & wstrb_q[0] & wr_hit;
  assign we_mask   = wr_lane0 & (wr_idx == `IPEI_OFF_IRQ_MASK);
  assign we_select = wr_lane0 & (wr_idx == `IPEI_OFF_GROUP_SELECT);
  assign we_gcmp   = wr_lane0 & (wr_idx == `IPEI_OFF_GROUP_COMPARE);
  assign we_scmp   = wr_lane0 & (wr_idx == `IPEI_OFF_SINGLE_COMPARE);

  // writable registers; flags and levels take no writes
  always @(posedge CLK) begin
    if (SRST) begin
      mask_q   <= `IPEI_RST_MASK;
      select_q <= `IPEI_RST_SELECT;
      gcmp_q   <= `IPEI_RST_GROUP_COMPARE;
      scmp_q   <= `IPEI_RST_SINGLE_COMPARE;
    end else begin
      if (we_mask)
        mask_q <= wdata_q[1:0];
      if (we_select)
        select_q <= wdata_q[GROUP_W-1:0];
      if (we_gcmp)
        gcmp_q <= wdata_q[GROUP_W-1:0];
      if (we_scmp)
        scmp_q <= wdata_q[0];
    end
  end

  // axi read channel
  // one read in flight: the address is refused until the answer is taken
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rresp_q;
  reg  [31:0] rd_mux;
  wire        rd_take;
  wire        rd_group_flag;
  wire        rd_single_flag;
  wire        rd_ok;

  assign S_AXI_ARREADY = ~rvalid_q;
  assign rd_take       = S_AXI_ARVALID & ~rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  // a flag read clears at the address edge; the answer keeps the old value
  assign rd_ok          = rd_take & rd_aligned;
  assign rd_group_flag  = rd_ok & (rd_idx == `IPEI_OFF_GROUP_FLAG);
  assign rd_single_flag = rd_ok & (rd_idx == `IPEI_OFF_SINGLE_FLAG);

  // misaligned or unmapped reads return zero
  always @* begin
    rd_mux = 32'h0000_0000;
    if (rd_aligned) begin
      case (rd_idx)
        `IPEI_OFF_SINGLE_FLAG:    rd_mux[0] = single_flag_q;
        `IPEI_OFF_GROUP_FLAG:     rd_mux[0] = group_flag_q;
        `IPEI_OFF_IRQ_MASK:       rd_mux[1:0] = mask_q;
        `IPEI_OFF_GROUP_SELECT:   rd_mux[GROUP_W-1:0] = select_q;
        `IPEI_OFF_GROUP_LEVELS:   rd_mux[GROUP_W-1:0] = group_s;
        `IPEI_OFF_SINGLE_LEVEL:   rd_mux[0] = single_s;
        `IPEI_OFF_GROUP_COMPARE:  rd_mux[GROUP_W-1:0] = gcmp_q;
        `IPEI_OFF_SINGLE_COMPARE: rd_mux[0] = scmp_q;
        `IPEI_OFF_SLEEP_CTRL:     rd_mux[0] = sleep_q;
        default:                  rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // answer registered on the edge that takes the address
  always @(posedge CLK) begin
    if (SRST) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `IPEI_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= (is_mapped(rd_idx) && rd_aligned) ? `IPEI_RESP_OKAY : `IPEI_RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // factor flags: set regardless of mask, cleared by read, set beats clear
  reg group_flag_d;
  reg single_flag_d;

  always @* begin
    group_flag_d  = group_flag_q;
    single_flag_d = single_flag_q;
    if (rd_group_flag)
      group_flag_d = 1'b0;
    if (group_evt)
      group_flag_d = 1'b1;
    if (rd_single_flag)
      single_flag_d = 1'b0;
    if (single_evt)
      single_flag_d = 1'b1;
  end

  always @(posedge CLK) begin
    if (SRST) begin
      group_flag_q  <= 1'b0;
      single_flag_q <= 1'b0;
    end else begin
      group_flag_q  <= group_flag_d;
      single_flag_q <= single_flag_d;
    end
  end

  // sleep: software writes one to enter, single pin event wakes
  wire sleep_wr;
  reg  sleep_d;
  assign sleep_wr = wr_lane0 & (wr_idx == `IPEI_OFF_SLEEP_CTRL);

  // a wake in the cycle of a sleep write wins, so no wake is lost
  always @* begin
    sleep_d = sleep_q;
    if (sleep_wr)
      sleep_d = wdata_q[0];
    if (single_evt)
      sleep_d = 1'b0;
  end

  always @(posedge CLK) begin
    if (SRST)
      sleep_q <= 1'b0;
    else
      sleep_q <= sleep_d;
  end
  assign SLEEP = sleep_q;

  // a flag only asks the cpu when its enable bit is one
  wire group_req;
  wire single_req;
  assign group_req  = group_flag_q & mask_q[`IPEI_MASK_GROUP_BIT];
  assign single_req = single_flag_q & mask_q[`IPEI_MASK_SINGLE_BIT];

  // mask written while cpu irqs are on may glitch this request; software avoids it
  assign IRQ = group_req | single_req;
endmodule

// File: bench/ipei_pins.sv
// external switch model driving the five input pins
`timescale 1ns/1ps
module ipei_pins (
  // requested levels
  input  logic [3:0] want_g,
  input  logic       want_s,
  // pins
  output logic [3:0] pin_g,
  output logic       pin_s
);
  // switch levels, held until the bench moves them; no bounce modelled
  assign pin_g = want_g;
  assign pin_s = want_s;
endmodule

// File: bench/ipei_top_asserts.sv
// port-level checks of the input port block
`timescale 1ns/1ps
module ipei_top_asserts (
  // clock and reset
  input wire        CLK,
  input wire        SRST,
  // cpu side
  input wire        IRQ,
  input wire        SLEEP,
  // bus
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire        S_AXI_WVALID,
  input wire        S_AXI_WREADY,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence wr_both;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  rd_latency_a: assert property (rd_take |=> S_AXI_RVALID)
    else $error("read data late");
  rd_once_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer repeated");
  ar_block_a: assert property (S_AXI_ARREADY == !S_AXI_RVALID)
    else $error("read address taken while answer pending");
  wr_resp_a: assert property (wr_both |-> ##[1:3] S_AXI_BVALID)
    else $error("write response late");
  bv_once_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
  rd_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:4] == 28'h0)
    else $error("upper read bits not zero");
  rst_quiet_a: assert property ($fell(SRST) |-> !IRQ && !SLEEP)
    else $error("request or sleep set after reset");
  rst_ready_a: assert property ($fell(SRST) |-> S_AXI_AWREADY && S_AXI_ARREADY)
    else $error("bus not ready after reset");
endmodule

// File: bench/tb.sv
// register-level bench of the input port block
`timescale 1ns/1ps
`include "ipei_defines.vh"
module tb;
  logic        clk = 0, srst = 1;
  logic [3:0]  want_g = 4'h0;
  logic        want_s = 1'b0;
  wire  [3:0]  pin_g;
  wire         pin_s, irq, slp, awr, wrdy, bv, arr, rv;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  logic [9:0]  aw = 10'h0, ar = 10'h0;
  logic [31:0] wd = 32'h0, d;
  logic        awv = 0, wv = 0, arv = 0;
  logic [1:0]  rs, bs;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  initial forever #2.5 clk = ~clk;
  ipei_pins pm (.want_g(want_g), .want_s(want_s), .pin_g(pin_g), .pin_s(pin_s));
  ipei_top dut (.CLK(clk), .SRST(srst), .GROUP_PIN(pin_g), .SINGLE_PIN(pin_s),
    .IRQ(irq), .SLEEP(slp), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1));
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      conclude();
    end
  end
  // settle half a cycle so edge updates have landed
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    @(negedge clk);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // ready sampled at the falling edge; inputs only move after rising edges
  // tasks take the register index; its byte address is four times it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic g, ta, tw;
    g = 0;
    @(posedge clk);
    aw <= {a, 2'b00}; wd <= v; awv <= 1; wv <= 1;
    while (!g) begin
      @(negedge clk);
      g = bv; bs = bresp;
      ta = awr && awv;
      tw = wrdy && wv;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end
  endtask
  task automatic rx(input logic [7:0] a, input logic [31:0] e);
    logic g, t;
    g = 0;
    @(posedge clk);
    ar <= {a, 2'b00}; arv <= 1;
    while (!g) begin
      @(negedge clk);
      g = rv; d = rdata; rs = rresp;
      t = arr && arv;
      @(posedge clk);
      if (t) arv <= 0;
    end
    chk(d, e);
  endtask
  // 2 sync flops plus flag register, with margin
  task automatic pins(input logic [3:0] g, input logic s);
    @(posedge clk);
    want_g <= g; want_s <= s;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    repeat (4) @(posedge clk);
    rx(`IPEI_OFF_IRQ_MASK, 0);
    rx(`IPEI_OFF_GROUP_SELECT, 0);
    rx(`IPEI_OFF_SINGLE_FLAG, 0);
    rx(`IPEI_OFF_GROUP_FLAG, 0);
    rx(8'h40, 0);
    chk(rs, `IPEI_RESP_SLVERR);
    wr(8'h40, 1);
    chk(bs, `IPEI_RESP_SLVERR);
    wr(`IPEI_OFF_IRQ_MASK, 32'hffff_fffc);
    chk(bs, `IPEI_RESP_OKAY);
    rx(`IPEI_OFF_IRQ_MASK, 0);
    $display("test reset done");
    pins(4'h5, 1);
    rx(`IPEI_OFF_GROUP_LEVELS, 5);
    rx(`IPEI_OFF_SINGLE_LEVEL, 1);
    wr(`IPEI_OFF_GROUP_LEVELS, 0);
    rx(`IPEI_OFF_GROUP_LEVELS, 5);
    chk(irq, 0);
    rx(`IPEI_OFF_SINGLE_FLAG, 1);
    rx(`IPEI_OFF_SINGLE_FLAG, 0);
    wr(`IPEI_OFF_SINGLE_FLAG, 1);
    rx(`IPEI_OFF_SINGLE_FLAG, 0);
    $display("test single done");
    wr(`IPEI_OFF_SINGLE_COMPARE, 1);
    rx(`IPEI_OFF_SINGLE_COMPARE, 1);
    rx(`IPEI_OFF_SINGLE_FLAG, 0);
    wr(`IPEI_OFF_SLEEP_CTRL, 1);
    chk(slp, 1);
    wr(`IPEI_OFF_IRQ_MASK, 2);
    pins(4'h5, 0);
    chk(irq, 1);
    chk(slp, 0);
    rx(`IPEI_OFF_SINGLE_FLAG, 1);
    chk(irq, 0);
    $display("test sleep done");
    pins(4'ha, 0);
    wr(`IPEI_OFF_GROUP_COMPARE, 4'ha);
    wr(`IPEI_OFF_GROUP_SELECT, 4'he);
    rx(`IPEI_OFF_GROUP_SELECT, 4'he);
    rx(`IPEI_OFF_GROUP_FLAG, 0);
    wr(`IPEI_OFF_IRQ_MASK, 1);
    pins(4'hb, 0);
    rx(`IPEI_OFF_GROUP_FLAG, 0);
    pins(4'h3, 0);
    chk(irq, 1);
    rx(`IPEI_OFF_GROUP_FLAG, 1);
    pins(4'h1, 0);
    rx(`IPEI_OFF_GROUP_FLAG, 0);
    rx(`IPEI_OFF_SINGLE_FLAG, 0);
    $display("test group done");
    conclude();
  end
endmodule
bind ipei_top ipei_top_asserts chk_u (.CLK(CLK), .SRST(SRST), .IRQ(IRQ), .SLEEP(SLEEP),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA));
